// ===== hdl/btg_pkg.sv
// Purpose: Shared constants and types for the billing tone generator
// Assumes: Byte-wide direct register port, 16-bit indirect coefficient space
// Notes: Offsets are register numbers on the direct register port
package btg_pkg;
  // Direct register numbers
  localparam logic [7:0] REG_IRQ_STATUS = 8'h14;  // Pending timer events, write one to clear
  localparam logic [7:0] REG_IND_LO = 8'h1c;      // Indirect data, low byte
  localparam logic [7:0] REG_IND_HI = 8'h1d;      // Indirect data, high byte
  localparam logic [7:0] REG_IND_WADDR = 8'h1e;   // Write here starts an indirect write
  localparam logic [7:0] REG_IND_RADDR = 8'h1f;   // Write here starts an indirect read
  localparam logic [7:0] REG_CTRL = 8'h23;        // billing_tone_control
  localparam logic [7:0] REG_ON_LO = 8'h2c;       // tone_on_period low byte
  localparam logic [7:0] REG_ON_HI = 8'h2d;       // tone_on_period high byte
  localparam logic [7:0] REG_OFF_LO = 8'h2e;      // tone_off_period low byte
  localparam logic [7:0] REG_OFF_HI = 8'h2f;      // tone_off_period high byte
  // Indirect register numbers
  localparam logic [7:0] IND_RAMP = 8'h17;        // tone_ramp_rate
  localparam logic [7:0] IND_AMP = 8'h18;         // tone_amplitude_coeff
  localparam logic [7:0] IND_FREQ = 8'h19;        // tone_frequency_coeff
  // Control and status field positions
  localparam int CTRL_STATE_BIT = 0;              // tone_state_flag, read only
  localparam int CTRL_ON_EN_BIT = 1;              // on_timer_enable
  localparam int CTRL_OFF_EN_BIT = 2;             // off_timer_enable
  localparam int CTRL_OUT_EN_BIT = 3;             // tone_output_enable
  localparam int IRQ_ON_BIT = 0;                  // On timer expired
  localparam int IRQ_OFF_BIT = 1;                 // Off timer expired
  // Reset values and limits
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] VOL_MAX = 16'h7fff;     // Envelope ceiling
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 64_000;                 // Oscillator computation rate
  localparam int ENV_HZ = 8_000;                  // Envelope and timer rate
  localparam int ENV_DIV = OSC_HZ / ENV_HZ;       // Oscillator ticks per envelope tick
  // Register port request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } btg_req_t;
  // Cadence states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ON = 3'b010,
    ST_OFF = 3'b100
  } btg_state_t;
endpackage : btg_pkg

// ===== hdl/btg_top.sv
// Purpose: Billing tone oscillator with envelope, cadence timers and output FIFO
// Assumes: Register port and DAC drain are synchronous to SYS_CLK
// Notes: One clock; 64 kHz and 8 kHz rates are enable pulses
`timescale 1ns/10ps

// Plain synchronous FIFO, flip-flop storage
module btg_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Pointer wrap relies on a power-of-two depth, so refuse anything else at build time
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage
  logic [AW-1:0] wr_ptr_ff;          // Write index
  logic [AW-1:0] rd_ptr_ff;          // Read index
  logic [AW:0] count_ff;             // Occupancy
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (count_ff != (AW + 1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];

  // Store on push
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      count_ff <= count_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : btg_fifo

module btg_top #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic [15:0] DAC_DATA,
  output logic DAC_VALID,
  input wire logic DAC_READY,
  output logic ON_TIMER_IRQ,
  output logic OFF_TIMER_IRQ
);
  // Refuse a FIFO too shallow to absorb a stall, at build time
  if (FIFO_DEPTH < 2) begin : g_bad_fifo
    $error("FIFO_DEPTH too small");
  end

  // Clamp a wide signed value into 16 bits
  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sd32767) return 16'h7fff;
    else if (v < -18'sd32768) return 16'h8000;
    else return v[15:0];
  endfunction : sat16

  btg_pkg::btg_req_t req;            // Register write request
  assign req = '{wr: REG_WR, addr: REG_ADDR, wdata: REG_WDATA};
  // Register address decodes
  wire wr_ctrl = req.wr && req.addr == btg_pkg::REG_CTRL;
  wire wr_irq = req.wr && req.addr == btg_pkg::REG_IRQ_STATUS;
  wire wr_ilo = req.wr && req.addr == btg_pkg::REG_IND_LO;
  wire wr_ihi = req.wr && req.addr == btg_pkg::REG_IND_HI;
  wire wr_iw = req.wr && req.addr == btg_pkg::REG_IND_WADDR;
  wire wr_ir = req.wr && req.addr == btg_pkg::REG_IND_RADDR;

  // Software state
  logic [15:0] ramp_ff;              // tone_ramp_rate
  logic [15:0] amp_ff;               // tone_amplitude_coeff
  logic [15:0] freq_ff;              // tone_frequency_coeff
  logic [15:0] ind_data_ff;          // Indirect data window
  logic [15:0] on_per_ff;            // tone_on_period
  logic [15:0] off_per_ff;           // tone_off_period
  logic on_en_ff;                    // on_timer_enable
  logic off_en_ff;                   // off_timer_enable
  logic out_en_ff;                   // tone_output_enable
  logic [1:0] irq_ff;                // Pending expiry events

  // Tone state
  btg_pkg::btg_state_t state_ff, nxt_state;
  logic [15:0] timer_ff, nxt_timer;  // Cadence down-counter
  logic [15:0] vol_ff, nxt_vol;      // Envelope volume
  logic [15:0] ya_ff, yb_ff;         // Last two oscillator samples
  logic [31:0] acc_ff;               // Fractional rate accumulator
  logic [2:0] envdiv_ff;             // Oscillator ticks to envelope tick
  logic on_exp, off_exp;             // Expiry pulses

  // 64 kHz from 100 MHz is not an integer ratio, so an accumulator spreads the
  // remainder instead of letting the tone frequency drift.
  wire [31:0] acc_sum = acc_ff + 32'(btg_pkg::OSC_HZ);
  wire osc_raw = acc_sum >= 32'(btg_pkg::CLK_HZ);
  wire fifo_ready;
  wire tick = osc_raw & fifo_ready;  // A full FIFO holds back the whole tone engine
  wire env_tick = tick && envdiv_ff == 3'(btg_pkg::ENV_DIV - 1);

  // Indirect read target
  wire [15:0] ind_rsel = (req.wdata == btg_pkg::IND_RAMP) ? ramp_ff :
                         (req.wdata == btg_pkg::IND_AMP) ? amp_ff :
                         (req.wdata == btg_pkg::IND_FREQ) ? freq_ff : btg_pkg::WORD_RST;

  // Rate dividers
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      acc_ff <= '0;
      envdiv_ff <= '0;
    end else begin
      acc_ff <= osc_raw ? acc_sum - 32'(btg_pkg::CLK_HZ) : acc_sum;
      if (tick) envdiv_ff <= env_tick ? 3'h0 : envdiv_ff + 3'h1;
    end
  end

  // Direct registers and the indirect window
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ramp_ff <= btg_pkg::WORD_RST;
      amp_ff <= btg_pkg::WORD_RST;
      freq_ff <= btg_pkg::WORD_RST;
      ind_data_ff <= btg_pkg::WORD_RST;
      on_per_ff <= btg_pkg::WORD_RST;
      off_per_ff <= btg_pkg::WORD_RST;
      {on_en_ff, off_en_ff, out_en_ff} <= 3'h0;
    end else begin
      if (wr_ilo) ind_data_ff[7:0] <= req.wdata;
      if (wr_ihi) ind_data_ff[15:8] <= req.wdata;
      if (wr_ir) ind_data_ff <= ind_rsel;
      if (wr_iw && req.wdata == btg_pkg::IND_RAMP) ramp_ff <= ind_data_ff;
      if (wr_iw && req.wdata == btg_pkg::IND_AMP) amp_ff <= ind_data_ff;
      if (wr_iw && req.wdata == btg_pkg::IND_FREQ) freq_ff <= ind_data_ff;
      if (req.wr && req.addr == btg_pkg::REG_ON_LO) on_per_ff[7:0] <= req.wdata;
      if (req.wr && req.addr == btg_pkg::REG_ON_HI) on_per_ff[15:8] <= req.wdata;
      if (req.wr && req.addr == btg_pkg::REG_OFF_LO) off_per_ff[7:0] <= req.wdata;
      if (req.wr && req.addr == btg_pkg::REG_OFF_HI) off_per_ff[15:8] <= req.wdata;
      if (wr_ctrl) begin
        on_en_ff <= req.wdata[btg_pkg::CTRL_ON_EN_BIT];
        off_en_ff <= req.wdata[btg_pkg::CTRL_OFF_EN_BIT];
        out_en_ff <= req.wdata[btg_pkg::CTRL_OUT_EN_BIT];
      end
    end
  end

  // Pending events; a new expiry wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      irq_ff <= 2'h0;
    end else begin
      irq_ff <= (irq_ff & ~(wr_irq ? req.wdata[1:0] : 2'h0)) | {off_exp, on_exp};
    end
  end
  assign ON_TIMER_IRQ = irq_ff[btg_pkg::IRQ_ON_BIT];
  assign OFF_TIMER_IRQ = irq_ff[btg_pkg::IRQ_OFF_BIT];

  // Register read mux
  wire [7:0] ctrl_rd = {4'h0, out_en_ff, off_en_ff, on_en_ff, state_ff == btg_pkg::ST_ON};
  assign REG_RDATA = (REG_ADDR == btg_pkg::REG_CTRL) ? ctrl_rd :
                     (REG_ADDR == btg_pkg::REG_IRQ_STATUS) ? {6'h0, irq_ff} :
                     (REG_ADDR == btg_pkg::REG_IND_LO) ? ind_data_ff[7:0] :
                     (REG_ADDR == btg_pkg::REG_IND_HI) ? ind_data_ff[15:8] :
                     (REG_ADDR == btg_pkg::REG_ON_LO) ? on_per_ff[7:0] :
                     (REG_ADDR == btg_pkg::REG_ON_HI) ? on_per_ff[15:8] :
                     (REG_ADDR == btg_pkg::REG_OFF_LO) ? off_per_ff[7:0] :
                     (REG_ADDR == btg_pkg::REG_OFF_HI) ? off_per_ff[15:8] : btg_pkg::BYTE_RST;

  // Cadence state machine and timer
  wire tmr_zero = (timer_ff == 16'h0000);
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    on_exp = 1'b0;
    off_exp = 1'b0;
    case (state_ff)
      btg_pkg::ST_IDLE: begin
        if (out_en_ff) begin
          nxt_state = btg_pkg::ST_ON;
          nxt_timer = on_per_ff;
        end
      end
      btg_pkg::ST_ON: begin
        if (!out_en_ff) begin
          nxt_state = btg_pkg::ST_IDLE;
        end else if (on_en_ff && env_tick) begin
          if (tmr_zero) begin
            on_exp = 1'b1;
            nxt_state = off_en_ff ? btg_pkg::ST_OFF : btg_pkg::ST_IDLE;
            nxt_timer = off_per_ff;
          end else begin
            nxt_timer = timer_ff - 16'h0001;
          end
        end
      end
      btg_pkg::ST_OFF: begin
        if (!out_en_ff || !off_en_ff) begin
          nxt_state = btg_pkg::ST_IDLE;
        end else if (env_tick) begin
          if (tmr_zero) begin
            off_exp = 1'b1;
            nxt_state = btg_pkg::ST_ON;
            nxt_timer = on_per_ff;
          end else begin
            nxt_timer = timer_ff - 16'h0001;
          end
        end
      end
      default: begin
        nxt_state = btg_pkg::ST_IDLE;
      end
    endcase
  end

  // State and cadence timer; a lone on period with output still enabled restarts next cycle
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_ff <= btg_pkg::ST_IDLE;
      timer_ff <= btg_pkg::WORD_RST;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
    end
  end

  // Envelope: saturating linear ramp toward ceiling or zero
  wire [16:0] vol_up = {1'b0, vol_ff} + {1'b0, ramp_ff};
  wire vol_on = (state_ff == btg_pkg::ST_ON);
  always_comb begin
    nxt_vol = vol_ff;
    if (env_tick && vol_on) begin
      nxt_vol = (vol_up > {1'b0, btg_pkg::VOL_MAX}) ? btg_pkg::VOL_MAX : vol_up[15:0];
    end else if (env_tick) begin
      nxt_vol = (vol_ff > ramp_ff) ? vol_ff - ramp_ff : 16'h0000;
    end
  end

  // Recursive oscillator: y[n] = 2c*y[n-1] - y[n-2], coefficient scaled by 2^15
  wire burst_start = (state_ff != btg_pkg::ST_ON) && (nxt_state == btg_pkg::ST_ON);
  wire signed [31:0] cy = $signed(freq_ff) * $signed(ya_ff);
  wire [15:0] y_next = sat16(18'(cy >>> 14) - 18'($signed(yb_ff)));
  wire running = vol_on || (vol_ff != 16'h0000);
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      vol_ff <= btg_pkg::WORD_RST;
      ya_ff <= btg_pkg::WORD_RST;
      yb_ff <= btg_pkg::WORD_RST;
    end else begin
      vol_ff <= nxt_vol;
      if (burst_start && !running) begin
        ya_ff <= btg_pkg::WORD_RST;
        yb_ff <= 16'h0000 - amp_ff;
      end else if (tick && running) begin
        ya_ff <= y_next;
        yb_ff <= ya_ff;
      end
    end
  end

  // Scale by envelope; silence once volume reaches zero outside ST_ON
  wire signed [32:0] scaled = $signed(ya_ff) * $signed({1'b0, vol_ff});
  wire [15:0] sample = running ? scaled[30:15] : 16'h0000;

  btg_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst(SRST),
    .in_valid(osc_raw),
    .in_ready(fifo_ready),
    .in_data(sample),
    .out_valid(DAC_VALID),
    .out_ready(DAC_READY),
    .out_data(DAC_DATA)
  );
endmodule : btg_top

// ===== tb/btg_checker.sv
// Purpose: Port assertions for the billing tone generator
// Assumes: One clock, SRST synchronous active high
// Notes: Bound to btg_top, sees its ports only
`timescale 1ns/10ps
module btg_checker #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic [15:0] DAC_DATA,
  input wire logic DAC_VALID,
  input wire logic DAC_READY,
  input wire logic ON_TIMER_IRQ,
  input wire logic OFF_TIMER_IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // Status writes, split per pending bit
  wire st_wr = REG_WR && REG_ADDR == btg_pkg::REG_IRQ_STATUS;
  wire clr_on = st_wr && REG_WDATA[btg_pkg::IRQ_ON_BIT];
  wire clr_off = st_wr && REG_WDATA[btg_pkg::IRQ_OFF_BIT];
  // Control write that drops the output enable
  wire ctrl_off = REG_WR && REG_ADDR == btg_pkg::REG_CTRL && !REG_WDATA[btg_pkg::CTRL_OUT_EN_BIT];
  // Period byte writes
  wire per_wr = REG_WR && REG_ADDR inside {8'h2c, 8'h2d, 8'h2e, 8'h2f};

  a_reset_quiet: assert property ($fell(SRST) |-> !DAC_VALID && !ON_TIMER_IRQ && !OFF_TIMER_IRQ)
    else $error("Outputs busy right after reset");
  a_on_clear_one: assert property ($fell(ON_TIMER_IRQ) |-> $past(clr_on))
    else $error("On event bit fell without a written one");
  a_off_clear_one: assert property ($fell(OFF_TIMER_IRQ) |-> $past(clr_off))
    else $error("Off event bit fell without a written one");
  a_irq_separate: assert property ($rose(ON_TIMER_IRQ) |-> !$rose(OFF_TIMER_IRQ))
    else $error("Both timer events rose together");
  a_ctrl_upper_zero: assert property (REG_ADDR == btg_pkg::REG_CTRL |-> REG_RDATA[7:4] == 4'h0)
    else $error("Control upper bits not zero");
  a_period_stored: assert property (per_wr ##1 (!REG_WR && $stable(REG_ADDR)) |->
    REG_RDATA == $past(REG_WDATA))
    else $error("Period byte not stored");
  a_dac_hold: assert property (DAC_VALID && !DAC_READY |=> DAC_VALID && $stable(DAC_DATA))
    else $error("Stalled sample changed or vanished");
  // State follows the enable one cycle late, so look two cycles after the write
  a_disable_idle: assert property (ctrl_off ##1 !REG_WR ##1
    REG_ADDR == btg_pkg::REG_CTRL |-> !REG_RDATA[btg_pkg::CTRL_STATE_BIT])
    else $error("Tone state kept after output disable");

  // Main scenarios reached
  c_on_event: cover property ($rose(ON_TIMER_IRQ));
  c_off_event: cover property ($rose(OFF_TIMER_IRQ));
  c_stall: cover property ((DAC_VALID && !DAC_READY) [*8]);
endmodule : btg_checker

bind btg_top btg_checker #(.FIFO_DEPTH(FIFO_DEPTH)) btg_checker_inst (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .DAC_DATA(DAC_DATA),
  .DAC_VALID(DAC_VALID), .DAC_READY(DAC_READY), .ON_TIMER_IRQ(ON_TIMER_IRQ),
  .OFF_TIMER_IRQ(OFF_TIMER_IRQ));

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the billing tone generator
// Assumes: Inputs driven 1 ns after the rising edge
// Notes: Row table for registers, hand tests for tone and timers
`timescale 1ns/10ps
module testbench;
  localparam int DEPTH = 16;                                 // FIFO words
  localparam int TICK8 = btg_pkg::CLK_HZ / btg_pkg::ENV_HZ;  // Cycles per 8 kHz step
  localparam int TICK64 = btg_pkg::CLK_HZ / btg_pkg::OSC_HZ; // Cycles per sample
  // One register case: write, then expected readback
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} btg_row_t;
  btg_row_t rows [8] = '{'{8'h2c, 8'ha5, 8'ha5}, '{8'h2d, 8'h5a, 8'h5a},
    '{8'h2e, 8'h3c, 8'h3c}, '{8'h2f, 8'hc3, 8'hc3}, '{8'h23, 8'h06, 8'h06},
    '{8'h23, 8'hf1, 8'h00}, '{8'h40, 8'hff, 8'h00}, '{8'h14, 8'hff, 8'h00}};
  logic [7:0] rst_addrs [8] = '{8'h14, 8'h1c, 8'h1d, 8'h23, 8'h2c, 8'h2d, 8'h2e, 8'h2f};
  logic [7:0] ind_idx [3] = '{8'h17, 8'h18, 8'h19};
  logic [15:0] ind_val [3] = '{16'h1234, 16'h4000, 16'h5a82};  // 8 kHz tone
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic REG_WR = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic DAC_READY = 1'b0;
  logic [7:0] REG_RDATA;
  logic [15:0] DAC_DATA;
  logic DAC_VALID;
  logic ON_TIMER_IRQ;
  logic OFF_TIMER_IRQ;
  int miscompares = 0;
  int compares = 0;
  int cnt;

  btg_top #(.FIFO_DEPTH(DEPTH)) btg_top_inst (.SYS_CLK(SYS_CLK), .SRST(SRST),
    .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .DAC_DATA(DAC_DATA), .DAC_VALID(DAC_VALID), .DAC_READY(DAC_READY),
    .ON_TIMER_IRQ(ON_TIMER_IRQ), .OFF_TIMER_IRQ(OFF_TIMER_IRQ));

  // 100 MHz clock
  always #5 SYS_CLK = ~SYS_CLK;

  // Single compare for every result, bytes and flags zero-extended
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    #1;
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(posedge SYS_CLK);
    #1;
    REG_WR = 1'b0;
  endtask : wr
  // Combinational read, checked once settled
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge SYS_CLK);
    #1;
    REG_ADDR = a;
    #1;
    chk({8'h00, REG_RDATA}, {8'h00, e}, what);
  endtask : rd
  // Indirect write: low, high, then index trigger
  task automatic ind_wr(input logic [7:0] idx, input logic [15:0] v);
    wr(btg_pkg::REG_IND_LO, v[7:0]);
    wr(btg_pkg::REG_IND_HI, v[15:8]);
    wr(btg_pkg::REG_IND_WADDR, idx);
  endtask : ind_wr
  // Wait for a nonzero sample, bounded
  task automatic wait_tone(input int lim);
    cnt = 0;
    while (cnt < lim && (DAC_VALID && DAC_DATA != 16'h0000) !== 1'b1) begin
      @(posedge SYS_CLK);
      #1;
      cnt++;
    end
  endtask : wait_tone
  // Verdict, the only exit
  task automatic stop_test;
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog well past the expected run
  initial begin
    repeat (90000) @(posedge SYS_CLK);
    miscompares++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge SYS_CLK);
    #1;
    SRST = 1'b0;
    foreach (rst_addrs[i]) rd(rst_addrs[i], 8'h00, "reset value");
    chk({15'h0, DAC_VALID}, 16'h0000, "valid after reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "register row");
    end
    // Write all three first so each read must fetch, not echo the window
    foreach (ind_idx[i]) ind_wr(ind_idx[i], ind_val[i]);
    foreach (ind_idx[i]) begin
      wr(btg_pkg::REG_IND_RADDR, ind_idx[i]);
      rd(btg_pkg::REG_IND_LO, ind_val[i][7:0], "indirect low");
      rd(btg_pkg::REG_IND_HI, ind_val[i][15:8], "indirect high");
    end
    // Zero ramp keeps volume at zero while the FIFO fills and refuses
    ind_wr(btg_pkg::IND_RAMP, 16'h0000);
    wr(btg_pkg::REG_CTRL, 8'h08);
    rd(btg_pkg::REG_CTRL, 8'h09, "tone state on");
    repeat ((DEPTH + 1) * TICK64) @(posedge SYS_CLK);
    #1;
    chk({15'h0, DAC_VALID}, 16'h0001, "full FIFO valid");
    for (int i = 0; i < DEPTH; i++) begin
      chk(DAC_DATA, 16'h0000, "silent sample");
      @(posedge SYS_CLK);
      #1;
      DAC_READY = 1'b1;
      @(posedge SYS_CLK);
      #1;
      DAC_READY = 1'b0;
    end
    chk({15'h0, DAC_VALID}, 16'h0000, "drained FIFO empty");
    // Ramp up, drained continuously
    DAC_READY = 1'b1;
    ind_wr(btg_pkg::IND_RAMP, 16'h4000);
    wait_tone(TICK8 + 2 * TICK64);
    chk({15'h0, cnt < TICK8 + 2 * TICK64}, 16'h0001, "tone rises");
    // Second step caps at the ceiling, then switch off
    repeat (TICK8) @(posedge SYS_CLK);
    wr(btg_pkg::REG_CTRL, 8'h00);
    wait_tone(4 * TICK64);
    chk({15'h0, cnt < 4 * TICK64}, 16'h0001, "tone fades, not cut");
    // Cadence with zero periods
    wr(btg_pkg::REG_ON_LO, 8'h00);
    wr(btg_pkg::REG_ON_HI, 8'h00);
    wr(btg_pkg::REG_OFF_LO, 8'h00);
    wr(btg_pkg::REG_OFF_HI, 8'h00);
    wr(btg_pkg::REG_CTRL, 8'h0e);
    cnt = 0;
    while (cnt < TICK8 + 100 && ON_TIMER_IRQ !== 1'b1) begin
      @(posedge SYS_CLK);
      #1;
      cnt++;
    end
    chk({15'h0, ON_TIMER_IRQ}, 16'h0001, "on expiry");
    rd(btg_pkg::REG_CTRL, 8'h0e, "off phase");
    cnt = 0;
    while (cnt < 2 * TICK8 && OFF_TIMER_IRQ !== 1'b1) begin
      @(posedge SYS_CLK);
      #1;
      cnt++;
    end
    // Off phase lasts one 8 kHz step, not one sample
    chk({15'h0, cnt > TICK8 - 30 && cnt < TICK8 + 30}, 16'h0001, "off length");
    rd(btg_pkg::REG_CTRL, 8'h0f, "back on");
    wr(btg_pkg::REG_IRQ_STATUS, 8'h00);
    chk({14'h0, OFF_TIMER_IRQ, ON_TIMER_IRQ}, 16'h0003, "zero write keeps");
    wr(btg_pkg::REG_IRQ_STATUS, 8'h03);
    chk({14'h0, OFF_TIMER_IRQ, ON_TIMER_IRQ}, 16'h0000, "one write clears");
    stop_test();
  end
endmodule : testbench
